// *** rtl/async_sixteen_bit_counter.sv ***
// Sixteen bit timer/counter with a crystal oscillator pin pair and an APB register slave.
// Assumes ref_clk at 50 MHz; the count clock pin is sampled on ref_clk and counted on edges.
//
// Function
// - Byte reads of the count return a settled, synchronised value.
// - A write colliding with an increment may leave an unpredictable count.
// - Oscillator enable bit 3 turns on the crystal amplifier between the pins.
// - The low-power oscillator, up to 37 kHz, keeps running in sleep.
// - The counter oscillator works only when the system clock is internal.
// - Oscillator enabled forces pin directions to input; pins then read zero.
// - Counting in sleep only happens in asynchronous external-clock mode.
// - Overflow wakes the device if counter on, overflow enable, peripheral enable set.
// - With global enable also set, the wake-up branches to the service routine.
// - Count is reached through low and high byte holding registers.
// - Asynchronous mode counts an external crystal or external clock source.
// - Sync disable bit 2 lets the external clock count without phase sync.
// - Asynchronous counting continues in sleep and may raise the overflow interrupt.
`timescale 1ns/10ps
module async_sixteen_bit_counter (
    input  wire logic                            ref_clk,
    input  wire logic                            resetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [counter_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            crystal_input_pin,
    input  wire logic                            gate_pin_n,
    output logic                                 crystal_drive_pin,
    output logic                                 crystal_drive_oe,
    input  wire logic                            sleep_mode,
    input  wire logic                            sys_clk_internal,
    input  wire logic                            dir_four_sw,
    input  wire logic                            dir_five_sw,
    input  wire logic                            pin_four_in,
    input  wire logic                            pin_five_in,
    output logic                                 pin_four_direction,
    output logic                                 pin_five_direction,
    output logic                                 port_pin_four,
    output logic                                 port_pin_five,
    output logic                                 wake_out,
    output logic                                 irq
);

    // ========================================================================
    // Declarations
    // ========================================================================
    counter_pkg::ctrl_t                  ctrl_q;
    counter_pkg::intctl_t                intctl_q;
    counter_pkg::count_t                 count_q;
    counter_pkg::count_t                 count_d;
    logic                                overflow_flag_q;
    logic                                overflow_int_enable_q;
    logic [1:0]                          div_q;
    logic [2:0]                          pre_q;
    logic [2:0]                          pre_limit;
    logic [3:0]                          sync_level;
    logic [3:0]                          sync_rise;
    logic [counter_pkg::IDX_W-1:0]       idx;
    logic                                aligned;
    logic                                mapped;
    logic                                access;
    logic                                wr_en;
    logic                                rd_en;
    logic                                int_tick;
    logic                                ext_edge;
    logic                                src_tick;
    logic                                async_mode;
    logic                                run_ok;
    logic                                inc;
    logic                                rollover;
    logic                                osc_active;
    logic                                wake_cond;
    logic [31:0]                         rd_value;

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    // Bit 0 is the count clock pin, bit 1 the gate, bits 2 and 3 the port pins.
    pin_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .clk     (ref_clk),
        .resetn  (resetn),
        .pin_in  ({pin_five_in, pin_four_in, gate_pin_n, crystal_input_pin}),
        .level_q (sync_level),
        .rise_q  (sync_rise)
    );

    // ========================================================================
    // APB decode
    // ========================================================================
    assign idx     = paddr[counter_pkg::ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign access  = psel & penable & pready;
    assign wr_en   = access & pwrite & mapped;
    assign rd_en   = access & ~pwrite & mapped;

    always_comb begin
        mapped   = 1'b0;
        rd_value = counter_pkg::READ_ZERO;
        if (aligned) begin
            case (idx)
                counter_pkg::IDX_INTERRUPT_CONTROL: begin
                    mapped   = 1'b1;
                    rd_value = {24'h000000, intctl_q};
                end
                counter_pkg::IDX_PERIPHERAL_FLAGS: begin
                    mapped   = 1'b1;
                    rd_value = {31'h00000000, overflow_flag_q};
                end
                counter_pkg::IDX_COUNT_LOW_BYTE: begin
                    mapped   = 1'b1;
                    rd_value = {24'h000000, count_q.low};
                end
                counter_pkg::IDX_COUNT_HIGH_BYTE: begin
                    mapped   = 1'b1;
                    rd_value = {24'h000000, count_q.high};
                end
                counter_pkg::IDX_COUNTER_CONTROL: begin
                    mapped   = 1'b1;
                    rd_value = {24'h000000, ctrl_q & counter_pkg::COUNTER_CONTROL_MASK};
                end
                counter_pkg::IDX_PERIPHERAL_ENABLES: begin
                    mapped   = 1'b1;
                    rd_value = {31'h00000000, overflow_int_enable_q};
                end
                default: begin
                    mapped   = 1'b0;
                    rd_value = counter_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // Read data is taken in the setup cycle, so every transfer has one wait-free
    // access cycle and prdata always comes from a register.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= counter_pkg::READ_ZERO;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable) begin
                prdata <= pwrite ? counter_pkg::READ_ZERO : rd_value;
            end
        end
    end

    // ========================================================================
    // Control registers
    // ========================================================================
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= counter_pkg::ctrl_t'(counter_pkg::COUNTER_CONTROL_RESET);
        end else if (wr_en && idx == counter_pkg::IDX_COUNTER_CONTROL) begin
            ctrl_q <= counter_pkg::ctrl_t'(pwdata[7:0] & counter_pkg::COUNTER_CONTROL_MASK);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            intctl_q <= counter_pkg::intctl_t'(counter_pkg::INTERRUPT_CONTROL_RESET);
        end else if (wr_en && idx == counter_pkg::IDX_INTERRUPT_CONTROL) begin
            intctl_q <= counter_pkg::intctl_t'(pwdata[7:0]);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            overflow_int_enable_q <= 1'b0;
        end else if (wr_en && idx == counter_pkg::IDX_PERIPHERAL_ENABLES) begin
            overflow_int_enable_q <= pwdata[counter_pkg::OVERFLOW_BIT];
        end
    end

    // ========================================================================
    // Count sources
    // ========================================================================
    // The internal source is the system clock divided down; it stops in sleep
    // because the system clock does.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 2'h0;
        end else if (!sleep_mode) begin
            div_q <= (div_q == counter_pkg::INT_TICK_LAST) ? 2'h0 : div_q + 2'h1;
        end
    end

    assign int_tick   = ~sleep_mode & (div_q == counter_pkg::INT_TICK_LAST);
    assign ext_edge   = sync_rise[0];
    assign src_tick   = ctrl_q.clock_source_sel ? ext_edge : int_tick;
    // Without sync disable the external edge is tied to the phase clocks, which
    // halt in sleep; with it set the count keeps going.
    assign async_mode = ctrl_q.clock_source_sel & ctrl_q.sync_disable;
    assign run_ok     = ctrl_q.counter_on
                      & (~ctrl_q.gate_enable | ~sync_level[1])
                      & (~sleep_mode | async_mode);

    always_comb begin
        case (ctrl_q.prescale_sel)
            2'h0:    pre_limit = 3'h0;
            2'h1:    pre_limit = 3'h1;
            2'h2:    pre_limit = 3'h3;
            default: pre_limit = 3'h7;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= 3'h0;
        end else if (src_tick && run_ok) begin
            pre_q <= (pre_q >= pre_limit) ? 3'h0 : pre_q + 3'h1;
        end
    end

    assign inc      = src_tick & run_ok & (pre_q >= pre_limit);
    assign rollover = inc & (count_q == counter_pkg::COUNT_ALL_ONES);

    // ========================================================================
    // Count holding registers
    // ========================================================================
    // A byte write wins over a coincident increment, so the other byte may be
    // one count ahead of what software expected; stop the counter first.
    always_comb begin
        count_d = count_q;
        if (inc) begin
            count_d = counter_pkg::count_t'(16'(count_q + 16'h0001));
        end
        if (wr_en && idx == counter_pkg::IDX_COUNT_LOW_BYTE) begin
            count_d.low = pwdata[7:0];
        end
        if (wr_en && idx == counter_pkg::IDX_COUNT_HIGH_BYTE) begin
            count_d.high = pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= counter_pkg::count_t'(counter_pkg::COUNT_RESET);
        end else begin
            count_q <= count_d;
        end
    end

    // ========================================================================
    // Overflow flag and interrupt
    // ========================================================================
    // Reading the flag register clears the flag in the access cycle; a rollover in that
    // same cycle keeps it set, but one in the setup cycle is cleared without being read.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            overflow_flag_q <= 1'b0;
        end else if (rollover) begin
            overflow_flag_q <= 1'b1;
        end else if (rd_en && idx == counter_pkg::IDX_PERIPHERAL_FLAGS) begin
            overflow_flag_q <= 1'b0;
        end else if (wr_en && idx == counter_pkg::IDX_PERIPHERAL_FLAGS) begin
            overflow_flag_q <= pwdata[counter_pkg::OVERFLOW_BIT];
        end
    end

    assign wake_cond = ctrl_q.counter_on & overflow_flag_q & overflow_int_enable_q
                     & intctl_q.peripheral_int_enable;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wake_out <= 1'b0;
            irq      <= 1'b0;
        end else begin
            wake_out <= wake_cond;
            irq      <= wake_cond & intctl_q.global_int_enable;
        end
    end

    // ========================================================================
    // Crystal oscillator and shared pins
    // ========================================================================
    // The amplifier shares circuitry with the system low-power oscillator, so
    // it only runs with an internal system clock; sleep does not stop it.
    assign osc_active = ctrl_q.counter_osc_enable & sys_clk_internal;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            crystal_drive_pin <= 1'b0;
            crystal_drive_oe  <= 1'b0;
        end else begin
            crystal_drive_pin <= ~sync_level[0];
            crystal_drive_oe  <= osc_active;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_four_direction <= 1'b1;
            pin_five_direction <= 1'b1;
            port_pin_four      <= 1'b0;
            port_pin_five      <= 1'b0;
        end else begin
            pin_four_direction <= ctrl_q.counter_osc_enable | dir_four_sw;
            pin_five_direction <= ctrl_q.counter_osc_enable | dir_five_sw;
            port_pin_four      <= ~ctrl_q.counter_osc_enable & sync_level[2];
            port_pin_five      <= ~ctrl_q.counter_osc_enable & sync_level[3];
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    a_read_settled: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        rd_en && idx == counter_pkg::IDX_COUNT_LOW_BYTE
        |-> prdata[7:0] == $past(count_q.low)
    ) else $error("count low byte read does not match the count");

    a_write_wins: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        wr_en && idx == counter_pkg::IDX_COUNT_HIGH_BYTE
        |=> count_q.high == $past(pwdata[7:0])
    ) else $error("high byte write not taken");

    a_osc_drive: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        ctrl_q.counter_osc_enable && sys_clk_internal |=> crystal_drive_oe
    ) else $error("oscillator enabled but amplifier off");

    a_osc_shared: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !sys_clk_internal ##1 !sys_clk_internal |-> !crystal_drive_oe
    ) else $error("oscillator running without internal system clock");

    a_dir_forced: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        ctrl_q.counter_osc_enable
        |=> pin_four_direction && pin_five_direction && !port_pin_four && !port_pin_five
    ) else $error("oscillator pins not forced to input");

    a_sleep_hold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        sleep_mode && !async_mode && !wr_en |=> count_q == $past(count_q)
    ) else $error("count moved in sleep outside asynchronous mode");

    a_async_count: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        sleep_mode && async_mode && ctrl_q.counter_on && !ctrl_q.gate_enable
        && ctrl_q.prescale_sel == 2'h0 && ext_edge && !wr_en
        |=> count_q == 16'($past(count_q) + 16'h0001)
    ) else $error("asynchronous count did not advance in sleep");

    a_overflow_flag: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        rollover |=> overflow_flag_q && count_q == counter_pkg::COUNT_RESET
    ) else $error("rollover did not set the overflow flag");

    a_wake_gate: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $rose(wake_out) |-> $past(ctrl_q.counter_on && overflow_flag_q
                                  && overflow_int_enable_q
                                  && intctl_q.peripheral_int_enable)
    ) else $error("wake raised without all enables");

    a_isr_gate: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        irq |-> wake_out && $past(intctl_q.global_int_enable)
    ) else $error("interrupt without wake or global enable");

endmodule

// *** rtl/counter_pkg.sv ***
// Shared constants and carrier types for the asynchronous sixteen bit counter.
// Assumes an APB slave with 32-bit data; register N sits at byte address 4*N.
package counter_pkg;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_W  = 10;

    // Printed offsets are register indices; the byte address is four times each.
    localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL  = 10'h00B;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_FLAGS   = 10'h00C;
    localparam logic [IDX_W-1:0] IDX_COUNT_LOW_BYTE     = 10'h00E;
    localparam logic [IDX_W-1:0] IDX_COUNT_HIGH_BYTE    = 10'h00F;
    localparam logic [IDX_W-1:0] IDX_COUNTER_CONTROL    = 10'h010;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_ENABLES = 10'h08C;

    // ========================================================================
    // Reset values and implemented bits
    // ========================================================================
    localparam logic [7:0]  INTERRUPT_CONTROL_RESET = 8'h00;
    localparam logic [7:0]  COUNTER_CONTROL_RESET   = 8'h00;
    localparam logic [7:0]  COUNTER_CONTROL_MASK    = 8'h7F;
    localparam logic [15:0] COUNT_RESET             = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES          = 16'hFFFF;
    localparam logic [31:0] READ_ZERO               = 32'h0000_0000;

    // Field positions inside the flag and enable registers.
    localparam int unsigned OVERFLOW_BIT = 0;

    // ========================================================================
    // Timing
    // ========================================================================
    // The internal count source runs at a quarter of the system clock.
    localparam int unsigned INT_TICK_DIV = 4;
    localparam logic [1:0]  INT_TICK_LAST = 2'(INT_TICK_DIV - 1);

    // ========================================================================
    // Carrier types
    // ========================================================================
    typedef struct packed {
        logic       spare;
        logic       gate_enable;
        logic [1:0] prescale_sel;
        logic       counter_osc_enable;
        logic       sync_disable;
        logic       clock_source_sel;
        logic       counter_on;
    } ctrl_t;

    typedef struct packed {
        logic       global_int_enable;
        logic       peripheral_int_enable;
        logic [5:0] other;
    } intctl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } count_t;

endpackage

// *** rtl/pin_sync.sv ***
// Two flip-flop synchroniser with rising edge detection for a group of pins.
// Assumes the inputs are asynchronous to clk; only the second stage is looked at.
`timescale 1ns/10ps
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_q,
    output logic      [WIDTH-1:0] rise_q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] prev_q;

    // ========================================================================
    // Synchroniser and edge detector
    // ========================================================================
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q  <= '0;
            level_q <= '0;
            prev_q  <= '0;
            rise_q  <= '0;
        end else begin
            meta_q  <= pin_in;
            level_q <= meta_q;
            prev_q  <= level_q;
            rise_q  <= level_q & ~prev_q;
        end
    end

endmodule

// *** bench/ext_clock_src.sv ***
// Model of an external count clock source driving the crystal input pin.
// Assumes the bench calls burst; the line rests low between bursts.
`timescale 1ns/10ps
module ext_clock_src (
    output logic pin
);
    // ========================================================================
    // Burst generator
    // ========================================================================
    initial pin = 1'b0;

    // A half period of 80 ns gives the 160 ns link clock; outside bursts it stands still.
    task automatic burst(input int n);
        repeat (n) begin
            pin = 1'b1;
            #80;
            pin = 1'b0;
            #80;
        end
    endtask
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the asynchronous sixteen bit counter.
// Assumes counter_pkg, pin_sync and the counter are compiled first.
`timescale 1ns/10ps
module tb_top;
    // ========================================================================
    // Signals
    // ========================================================================
    localparam logic [11:0] A_ICON = 12'h02C, A_FLAG = 12'h030, A_LOW = 12'h038;
    localparam logic [11:0] A_HIGH = 12'h03C, A_CTL = 12'h040, A_PIE = 12'h230;
    logic        ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, gate_pin_n = 1'b0, sleep_mode = 1'b0;
    logic        sys_clk_internal = 1'b1, dir_four_sw = 1'b0, dir_five_sw = 1'b0;
    logic        pin_four_in = 1'b1, pin_five_in = 1'b1, crystal_input_pin;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic        pready, pslverr, crystal_drive_pin, crystal_drive_oe, wake_out, irq;
    logic        pin_four_direction, pin_five_direction, port_pin_four, port_pin_five;
    int          fail_count = 0, n_checks = 0, cyc = 0;

    always #10 ref_clk = ~ref_clk;

    async_sixteen_bit_counter DUT (
        .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .crystal_input_pin, .gate_pin_n, .crystal_drive_pin, .crystal_drive_oe,
        .sleep_mode, .sys_clk_internal, .dir_four_sw, .dir_five_sw, .pin_four_in,
        .pin_five_in, .pin_four_direction, .pin_five_direction, .port_pin_four,
        .port_pin_five, .wake_out, .irq
    );
    ext_clock_src xtal (.pin(crystal_input_pin));

    // ========================================================================
    // Bus and compare tasks
    // ========================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_reset();
        rd(A_CTL, 32'h0000_0000, 1'b0);
        rd(A_ICON, 32'h0000_0000, 1'b0);
        rd(12'h3FC, 32'h0000_0000, 1'b1);
    endtask

    task automatic t_osc();
        chk({31'h0, pin_four_direction}, 32'h0000_0000);
        chk({31'h0, port_pin_four}, 32'h0000_0001);
        wr(A_CTL, 32'h0000_0008);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, pin_four_direction}, 32'h0000_0001);
        chk({31'h0, port_pin_four}, 32'h0000_0000);
        chk({31'h0, pin_five_direction}, 32'h0000_0001);
        chk({31'h0, port_pin_five}, 32'h0000_0000);
        chk({31'h0, crystal_drive_oe}, 32'h0000_0001);
        chk({31'h0, crystal_drive_pin}, 32'h0000_0001);
        sys_clk_internal <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({31'h0, crystal_drive_oe}, 32'h0000_0000);
        sys_clk_internal <= 1'b1;
        repeat (20) @(posedge ref_clk);
    endtask

    task automatic t_wake();
        wr(A_LOW, 32'h0000_00FF);
        wr(A_HIGH, 32'h0000_00FF);
        wr(A_PIE, 32'h0000_0001);
        wr(A_ICON, 32'h0000_00C0);
        sleep_mode <= 1'b1;
        wr(A_CTL, 32'h0000_000F);
        #7 xtal.burst(4);
        repeat (6) @(posedge ref_clk);
        chk({31'h0, wake_out}, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({31'h0, crystal_drive_oe}, 32'h0000_0001);
        rd(A_LOW, 32'h0000_0003, 1'b0);
        rd(A_HIGH, 32'h0000_0000, 1'b0);
        rd(A_FLAG, 32'h0000_0001, 1'b0);
        rd(A_FLAG, 32'h0000_0000, 1'b0);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask

    task automatic t_freeze();
        wr(A_CTL, 32'h0000_000B);
        #7 xtal.burst(2);
        repeat (6) @(posedge ref_clk);
        rd(A_LOW, 32'h0000_0003, 1'b0);
        sleep_mode <= 1'b0;
    endtask

    // Software reads high, low, high; a changed high byte exposes a split read.
    task automatic t_split();
        wr(A_CTL, 32'h0000_0008);
        wr(A_LOW, 32'h0000_00FF);
        wr(A_HIGH, 32'h0000_0000);
        wr(A_CTL, 32'h0000_001B);
        rd(A_HIGH, 32'h0000_0000, 1'b0);
        #7 xtal.burst(2);
        repeat (6) @(posedge ref_clk);
        rd(A_LOW, 32'h0000_0000, 1'b0);
        rd(A_HIGH, 32'h0000_0001, 1'b0);
        gate_pin_n <= 1'b1;
        wr(A_CTL, 32'h0000_004B);
        #7 xtal.burst(2);
        repeat (6) @(posedge ref_clk);
        rd(A_LOW, 32'h0000_0000, 1'b0);
    endtask

    // ========================================================================
    // Sequence and verdict
    // ========================================================================
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_osc();
        t_wake();
        t_freeze();
        t_split();
        finish_test();
    end
endmodule
